//--- sim/adcrs_cmp_model.sv
// Ideal comparator standing in for the analog front end
`timescale 1ns/100ps
module adcrs_cmp_model (
  input  wire logic [9:0] dacCode,
  input  wire logic [9:0] inLevel,
  output logic            cmpHigh
);
  // Level is pre-scaled to code steps; differential levels are offset binary
  assign cmpHigh = (inLevel >= dacCode);
endmodule // adcrs_cmp_model

//--- sim/adcrs_props.sv
// Checker of bus, sleep and result-port relations at the converter top
`timescale 1ns/100ps
module adcrs_props (
  input logic        sys_clk,
  input logic        reset_n,
  input logic        hsel,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        cpuHalted,
  input logic [2:0]  sleepMode,
  input logic [9:0]  dacCode,
  input logic [4:0]  channelSelect,
  input logic [1:0]  refSelect,
  input logic        converterPowered,
  input logic        convDoneIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Zero-wait slave that never errors
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or response not OKAY");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // Checked during reset too, so the reset disable is switched off here
  a_reset_quiet: assert property (@(posedge sys_clk) disable iff (1'b0)
    !reset_n |=> !converterPowered && !convDoneIrq && dacCode == 10'h000)
    else $error("outputs not cleared by reset");
  a_deep_keeps: assert property ($rose(cpuHalted) && sleepMode > 3'h1 && converterPowered
    |=> converterPowered) else $error("deep sleep switched the converter off");
  // The sequencer sees the enable one edge late, so the code is cleared from the second off cycle
  a_off_dac_still: assert property (!converterPowered && $past(!converterPowered)
    |-> dacCode == 10'h000) else $error("trial code not cleared while converter off");
  // Done request only drops after a software write two edges back
  a_irq_clear_write: assert property ($fell(convDoneIrq)
    |-> $past(hsel && htrans[1] && hwrite, 2)) else $error("done request dropped by itself");
  a_chan_held: assert property (converterPowered && $changed(dacCode)
    |-> $stable(channelSelect)) else $error("channel changed during conversion");
  a_ref_held: assert property (converterPowered && $changed(dacCode)
    |-> $stable(refSelect)) else $error("reference changed during conversion");

  c_irq_rise: cover property ($rose(convDoneIrq));
  c_noise_halt: cover property ($rose(cpuHalted) && sleepMode == 3'h1);
  c_abort: cover property ($fell(converterPowered));
endmodule // adcrs_props

bind adcrs_top adcrs_props props_u (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cpuHalted(cpuHalted), .sleepMode(sleepMode), .dacCode(dacCode),
  .channelSelect(channelSelect), .refSelect(refSelect), .converterPowered(converterPowered),
  .convDoneIrq(convDoneIrq));

//--- sim/adcrs_top_test.sv
// Self-checking bench for the converter result and sleep block
`timescale 1ns/100ps
module adcrs_top_test;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        cpuHalted = 1'b0;
  logic [2:0]  sleepMode = 3'h0;
  logic [9:0]  inLevel = 10'h000;
  logic        cmpHigh;
  logic [9:0]  dacCode;
  logic        converterPowered;
  logic        convDoneIrq;
  logic [31:0] rdVal;
  logic [4:0]  chanSel;
  logic [1:0]  refSel;
  int          err_total = 0;
  int          n_tests = 0;

  // Clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  adcrs_top #(.PRESCALE(1)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpuHalted(cpuHalted), .sleepMode(sleepMode), .cmpHigh(cmpHigh), .dacCode(dacCode),
    .channelSelect(chanSel), .refSelect(refSel), .converterPowered(converterPowered),
    .convDoneIrq(convDoneIrq));
  adcrs_cmp_model cmp_u (.dacCode(dacCode), .inLevel(inLevel), .cmpHigh(cmpHigh));

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    n_tests++;
    if (got !== expv) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, expv, got);
    end
  endtask

  // One AHB single transfer plus an idle cycle, so a read never sees stale data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdVal = hrdata;
    @(posedge sys_clk);
  endtask

  function automatic int clip(input int v, input int lo, input int hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  // Convert at a signed input in code steps; expected bytes come from the code rules
  task automatic convert(input logic [7:0] chan, input int v);
    logic       diff;
    logic [9:0] code;
    diff = (chan[4:0] >= 5'h08) && (chan[4:0] <= 5'h1D);
    code = diff ? 10'(clip(v, -512, 511)) : 10'(clip(v, 0, 1023));
    inLevel <= 10'(clip(diff ? v + 512 : v, 0, 1023));
    xfer(1'b1, 8'h04, {24'h000000, chan});
    chk("channel out", 32'(chan[4:0]), {27'h0000000, chanSel});
    chk("reference out", 32'(chan[7:6]), {30'h00000000, refSel});
    xfer(1'b1, 8'h00, 32'h000000C0);
    rdVal = 32'h00000000;
    for (int i = 0; i < 40 && rdVal[4] !== 1'b1; i++) xfer(1'b0, 8'h00, 32'h00000000);
    chk("done flag", 32'h00000001, {31'h00000000, rdVal[4]});
    xfer(1'b0, 8'h0C, 32'h00000000);
    chk("result high", 32'(chan[5] ? code[9:2] : {6'h00, code[9:8]}), rdVal);
    xfer(1'b0, 8'h08, 32'h00000000);
    chk("result low", 32'(chan[5] ? {code[1:0], 6'h00} : code[7:0]), rdVal);
    xfer(1'b1, 8'h00, 32'h00000090);
  endtask

  task automatic t_reset_map;
    for (int a = 0; a <= 20; a += 4) begin
      xfer(1'b0, 8'(a), 32'h00000000);
      chk("reset read", 32'h00000000, rdVal);
    end
    $display("reset map done");
  endtask

  task automatic t_codes;
    convert(8'h00, 0);
    convert(8'h20, 1023);
    convert(8'hC0, 1500);
    convert(8'h0D, -400);
    convert(8'h2D, -400);
    convert(8'h10, 600);
    convert(8'h30, -600);
    convert(8'h1A, 0);
    $display("result codes done");
  endtask

  // Flip justification on a known result (0x270), then again while converting
  task automatic t_justify;
    convert(8'h2D, -400);
    xfer(1'b1, 8'h04, 32'h0000000D);
    xfer(1'b0, 8'h0C, 32'h00000000);
    chk("right high", 32'h00000002, rdVal);
    xfer(1'b0, 8'h08, 32'h00000000);
    chk("right low", 32'h00000070, rdVal);
    xfer(1'b1, 8'h00, 32'h000000C0);
    xfer(1'b1, 8'h04, 32'h0000002D);
    xfer(1'b0, 8'h0C, 32'h00000000);
    chk("left high busy", 32'h0000009C, rdVal);
    repeat (40) @(posedge sys_clk);
    xfer(1'b1, 8'h00, 32'h00000090);
    $display("justify done");
  endtask

  // Sleep start in idle and noise modes; CPU woken early still gets the request
  task automatic t_sleep;
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, 8'h00, 32'h00000088);
      sleepMode <= 3'(m);
      cpuHalted <= 1'b1;
      repeat (2) @(posedge sys_clk);
      cpuHalted <= 1'b0;
      for (int i = 0; i < 60 && convDoneIrq !== 1'b1; i++) @(negedge sys_clk);
      chk("sleep done request", 32'h00000001, {31'h00000000, convDoneIrq});
      @(posedge sys_clk);
      xfer(1'b1, 8'h00, 32'h00000098);
      chk("request cleared", 32'h00000000, {31'h00000000, convDoneIrq});
    end
    $display("sleep done");
  endtask

  task automatic t_deep;
    sleepMode <= 3'h2;
    cpuHalted <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("deep powered", 32'h00000001, {31'h00000000, converterPowered});
    chk("deep no request", 32'h00000000, {31'h00000000, convDoneIrq});
    cpuHalted <= 1'b0;
    sleepMode <= 3'h0;
    xfer(1'b1, 8'h00, 32'h00000000);
    $display("deep sleep done");
  endtask

  task automatic t_abort;
    xfer(1'b1, 8'h00, 32'h000000C0);
    xfer(1'b1, 8'h00, 32'h00000000);
    chk("abort off", 32'h00000000, {31'h00000000, converterPowered});
    repeat (40) @(posedge sys_clk);
    xfer(1'b0, 8'h00, 32'h00000000);
    chk("abort no done", 32'h00000000, rdVal);
    $display("abort done");
  endtask

  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset_map;
    t_codes;
    t_justify;
    t_sleep;
    t_deep;
    t_abort;
    complete_run;
  end
endmodule // adcrs_top_test

//--- verilog/adcrs_map.vh
// Register offsets, field positions and timing counts of the converter result block
`ifndef ADCRS_MAP_VH
`define ADCRS_MAP_VH
// Register byte offsets (low address byte)
`define ADCRS_OFS_CTRL      8'h00
`define ADCRS_OFS_CHAN      8'h04
`define ADCRS_OFS_RES_LOW   8'h08
`define ADCRS_OFS_RES_HIGH  8'h0C
`define ADCRS_OFS_STATUS    8'h10
// Control register fields
`define ADCRS_CTRL_ENABLE   7
`define ADCRS_CTRL_START    6
`define ADCRS_CTRL_AUTORUN  5
`define ADCRS_CTRL_DONE     4
`define ADCRS_CTRL_IRQEN    3
// Channel select register fields
`define ADCRS_CHAN_REF_HI   7
`define ADCRS_CHAN_REF_LO   6
`define ADCRS_CHAN_LEFT     5
`define ADCRS_CHAN_MUX_HI   4
// Channel codes holding differential pairs
`define ADCRS_DIFF_FIRST    5'h08
`define ADCRS_DIFF_LAST     5'h1D
// Sleep mode codes seen from the CPU core
`define ADCRS_SLEEP_IDLE    3'h0
`define ADCRS_SLEEP_NOISE   3'h1
// Code constants and timing counts
`define ADCRS_SIGN_FLIP     10'h200
`define ADCRS_MSB_TRIAL     10'h200
`define ADCRS_LSB_TRIAL     10'h001
`define ADCRS_MSB_INDEX     4'h9
`define ADCRS_RESET_CODE    10'h000
`define ADCRS_INIT_STEPS    8'h0C
`define ADCRS_PRESCALE      2
`endif

//--- verilog/adcrs_sar.v
// Successive-approximation sequencer driving the DAC trial code
`timescale 1ns/100ps
`include "adcrs_map.vh"
module adcrs_sar #(
  parameter PRESCALE = `ADCRS_PRESCALE
) (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       enable,
  input  wire       startPulse,
  input  wire       firstConv,
  input  wire       cmpHigh,
  output wire [9:0] dacCode,
  output wire       busy,
  output reg        donePulse,
  output reg  [9:0] code
);
  localparam S_IDLE = 2'b00;
  localparam S_INIT = 2'b01;
  localparam S_BIT  = 2'b10;

  reg [1:0]  state_q;
  reg [15:0] divCnt_q;
  reg [7:0]  initCnt_q;
  reg [3:0]  bitIdx_q;
  reg [9:0]  work_q;
  wire       divTick;
  wire [9:0] trialBit;
  wire [9:0] kept;

  assign divTick  = (divCnt_q == PRESCALE[15:0] - 16'h0001);
  assign trialBit = `ADCRS_LSB_TRIAL << bitIdx_q;
  // Comparator high means the input is at or above the trial code
  assign kept     = cmpHigh ? work_q : (work_q & ~trialBit);
  assign dacCode  = work_q;
  assign busy     = (state_q != S_IDLE);

  // Clearing enable drops the sequence at once, losing any partial code
  always @(posedge sys_clk) begin
    if (!reset_n || !enable) begin
      state_q   <= S_IDLE;
      divCnt_q  <= 16'h0000;
      initCnt_q <= 8'h00;
      bitIdx_q  <= 4'h0;
      work_q    <= `ADCRS_RESET_CODE;
      donePulse <= 1'b0;
      if (!reset_n) begin
        code <= `ADCRS_RESET_CODE;
      end
    end else begin
      donePulse <= 1'b0;
      divCnt_q  <= divTick ? 16'h0000 : divCnt_q + 16'h0001;
      case (state_q)
        S_IDLE: begin
          divCnt_q <= 16'h0000;
          if (startPulse) begin
            work_q    <= `ADCRS_MSB_TRIAL;
            bitIdx_q  <= `ADCRS_MSB_INDEX;
            initCnt_q <= 8'h00;
            state_q   <= firstConv ? S_INIT : S_BIT;
          end
        end
        S_INIT: begin
          // Extended first conversion spends extra steps settling
          if (divTick) begin
            initCnt_q <= initCnt_q + 8'h01;
            if (initCnt_q == `ADCRS_INIT_STEPS - 8'h01) begin
              state_q <= S_BIT;
            end
          end
        end
        S_BIT: begin
          if (divTick) begin
            work_q <= kept | (trialBit >> 1);
            if (bitIdx_q == 4'h0) begin
              code      <= kept;
              donePulse <= 1'b1;
              state_q   <= S_IDLE;
            end else begin
              bitIdx_q <= bitIdx_q - 4'h1;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // adcrs_sar

//--- verilog/adcrs_top.v
// Converter control: AHB-Lite registers, result formatting and sleep-started conversion
`timescale 1ns/100ps
`include "adcrs_map.vh"
// Function
// - Completed 10-bit result readable across two bytes
// - Single-ended result is plain unsigned code
// - Differential result scaled by gain times 512
// - Differential codes two's complement, saturating
// - Result sign sits in top bit
// - Left or right justification of result bytes
// - Idle or noise sleep with converter enabled, idle, free-run off starts conversion
// - Completion request raised even after other wake
// - Other sleep modes leave converter enabled
// - Same channel on both inputs measures offset
// - Justification bit acts on result immediately
// - Enable bit powers converter; clearing aborts conversion
module adcrs_top #(
  parameter PRESCALE = `ADCRS_PRESCALE
) (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        cpuHalted,
  input  wire [2:0]  sleepMode,
  input  wire        cmpHigh,
  output wire [9:0]  dacCode,
  output wire [4:0]  channelSelect,
  output wire [1:0]  refSelect,
  output wire        converterPowered,
  output wire        convDoneIrq
);
  // Control and channel registers
  reg        enable_q;
  reg        start_q;
  reg        autoRun_q;
  reg        doneFlag_q;
  reg        irqEn_q;
  reg [1:0]  refSel_q;
  reg        leftJust_q;
  reg [4:0]  muxSel_q;
  // Conversion bookkeeping
  reg        launched_q;
  reg [4:0]  lockMux_q;
  reg [1:0]  lockRef_q;
  reg        firstPend_q;
  reg        sleepConv_q;
  reg        halted_q;
  reg [9:0]  result_q;
  // Bus data phase
  reg        dataWr_q;
  reg [7:0]  dataAddr_q;
  reg [31:0] rdata_q;

  wire       accept;
  wire       ctrlWr;
  wire       chanWr;
  wire       sarBusy;
  wire       sarDone;
  wire [9:0] sarCode;
  wire       launch;
  wire       sleepOk;
  wire       autoStart;
  wire       lockDiff;
  wire [7:0] lowByte;
  wire [7:0] highByte;
  wire [7:0] ctrlByte;
  wire [7:0] chanByte;
  reg  [7:0] readByte;

  // Zero-wait slave, always OKAY; read data latched at the address phase
  assign accept    = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign ctrlWr    = dataWr_q & (dataAddr_q == `ADCRS_OFS_CTRL);
  assign chanWr    = dataWr_q & (dataAddr_q == `ADCRS_OFS_CHAN);

  // Justification is applied at read time so a change shows at once
  assign lowByte  = leftJust_q ? {result_q[1:0], 6'h00} : result_q[7:0];
  assign highByte = leftJust_q ? result_q[9:2] : {6'h00, result_q[9:8]};
  assign ctrlByte = {enable_q, start_q, autoRun_q, doneFlag_q, irqEn_q, 3'h0};
  assign chanByte = {refSel_q, leftJust_q, muxSel_q};

  // Register read multiplexer, unmapped offsets read zero
  always @* begin
    case (haddr[7:0])
      `ADCRS_OFS_CTRL:     readByte = ctrlByte;
      `ADCRS_OFS_CHAN:     readByte = chanByte;
      `ADCRS_OFS_RES_LOW:  readByte = lowByte;
      `ADCRS_OFS_RES_HIGH: readByte = highByte;
      `ADCRS_OFS_STATUS:   readByte = {5'h00, firstPend_q, sleepConv_q, sarBusy};
      default:             readByte = 8'h00;
    endcase
  end

  // Address phase capture and read data register
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      dataWr_q   <= 1'b0;
      dataAddr_q <= 8'h00;
      rdata_q    <= 32'h00000000;
    end else begin
      dataWr_q <= accept & hwrite;
      if (accept) begin
        dataAddr_q <= haddr[7:0];
      end
      if (accept && !hwrite) begin
        rdata_q <= {24'h000000, readByte};
      end
    end
  end

  // Sleep start only from idle or noise-reduction sleep; deeper modes are
  // left alone and the converter keeps its enable state
  assign sleepOk   = (sleepMode == `ADCRS_SLEEP_IDLE) | (sleepMode == `ADCRS_SLEEP_NOISE);
  assign autoStart = cpuHalted & ~halted_q & sleepOk & enable_q & ~start_q
                     & ~sarBusy & ~launched_q & ~autoRun_q;
  assign launch    = enable_q & start_q & ~launched_q & ~sarBusy;

  // Channel code range holding differential pairs, including same-pin pairs
  assign lockDiff = (lockMux_q >= `ADCRS_DIFF_FIRST) & (lockMux_q <= `ADCRS_DIFF_LAST);

  // Selection is live until a conversion starts, then held until it ends
  assign channelSelect    = launched_q ? lockMux_q : muxSel_q;
  assign refSelect        = launched_q ? lockRef_q : refSel_q;
  assign converterPowered = enable_q;
  // Request follows the sticky flag, whatever woke the CPU
  assign convDoneIrq      = doneFlag_q & irqEn_q;

  // Control register, start handshake and result capture
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      enable_q    <= 1'b0;
      start_q     <= 1'b0;
      autoRun_q   <= 1'b0;
      doneFlag_q  <= 1'b0;
      irqEn_q     <= 1'b0;
      launched_q  <= 1'b0;
      lockMux_q   <= 5'h00;
      lockRef_q   <= 2'h0;
      firstPend_q <= 1'b0;
      sleepConv_q <= 1'b0;
      halted_q    <= 1'b0;
      result_q    <= `ADCRS_RESET_CODE;
    end else begin
      halted_q <= cpuHalted;
      if (ctrlWr) begin
        enable_q  <= hwdata[`ADCRS_CTRL_ENABLE];
        autoRun_q <= hwdata[`ADCRS_CTRL_AUTORUN];
        irqEn_q   <= hwdata[`ADCRS_CTRL_IRQEN];
      end
      // Start is set by software or by sleep entry; a zero write does nothing
      if ((ctrlWr && hwdata[`ADCRS_CTRL_START]) || autoStart) begin
        start_q <= 1'b1;
      end else if (sarDone && !autoRun_q) begin
        start_q <= 1'b0;
      end
      if (autoStart) begin
        sleepConv_q <= 1'b1;
      end else if (sarDone) begin
        sleepConv_q <= 1'b0;
      end
      // First conversion after enabling runs the extended sequence
      if (ctrlWr && hwdata[`ADCRS_CTRL_ENABLE] && !enable_q) begin
        firstPend_q <= 1'b1;
      end else if (launch) begin
        firstPend_q <= 1'b0;
      end
      if (launch) begin
        launched_q <= 1'b1;
        lockMux_q  <= muxSel_q;
        lockRef_q  <= refSel_q;
      end else if (sarDone) begin
        launched_q <= 1'b0;  // Free-run relaunches next cycle while start stays set
      end
      // Set wins over a write-one clear in the same cycle
      doneFlag_q <= sarDone | (doneFlag_q & ~(ctrlWr & hwdata[`ADCRS_CTRL_DONE]));
      if (sarDone) begin
        // Offset-binary SAR code flips its top bit into two's complement;
        // the SAR range itself gives the saturation at both ends
        result_q <= lockDiff ? (sarCode ^ `ADCRS_SIGN_FLIP) : sarCode;
      end
      // Disabling aborts: pending start and lock are dropped
      if (!enable_q) begin
        start_q     <= (ctrlWr & hwdata[`ADCRS_CTRL_START] & hwdata[`ADCRS_CTRL_ENABLE]);
        launched_q  <= 1'b0;
        sleepConv_q <= 1'b0;
      end
    end
  end

  // Channel select register; reference and justification are software choices
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      refSel_q   <= 2'h0;
      leftJust_q <= 1'b0;
      muxSel_q   <= 5'h00;
    end else if (chanWr) begin
      refSel_q   <= hwdata[`ADCRS_CHAN_REF_HI:`ADCRS_CHAN_REF_LO];
      leftJust_q <= hwdata[`ADCRS_CHAN_LEFT];
      muxSel_q   <= hwdata[`ADCRS_CHAN_MUX_HI:0];
    end
  end

  // Bit sequencer; aborted by the enable bit
  adcrs_sar #(
    .PRESCALE (PRESCALE)
  ) uSar (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .enable     (enable_q),
    .startPulse (launch),
    .firstConv  (firstPend_q),
    .cmpHigh    (cmpHigh),
    .dacCode    (dacCode),
    .busy       (sarBusy),
    .donePulse  (sarDone),
    .code       (sarCode)
  );
endmodule // adcrs_top
